// file: src/asf_pkg.sv
// package: flag register layout, instruction and addressing-mode codes
package asf_pkg;
   localparam int unsigned ASF_DW       = 8;
   localparam int unsigned ASF_FW       = 5;
   localparam int unsigned ASF_N_BIT    = 4;
   localparam int unsigned ASF_SOVF_BIT = 3;
   localparam int unsigned ASF_Z_BIT    = 2;
   localparam int unsigned ASF_NCY_BIT  = 1;
   localparam int unsigned ASF_C_BIT    = 0;
   localparam int unsigned ASF_MSB      = 7;
   localparam int unsigned ASF_LSB      = 0;
   localparam int unsigned ASF_NIB_HI   = 4;
   localparam int unsigned ASF_NIB_LO   = 3;
   localparam logic [7:0]  ASF_ZERO8    = 8'h00;
   localparam logic [7:0]  ASF_ONE8     = 8'h01;
   localparam logic [4:0]  ASF_FLAGS_RST = 5'h00;
   localparam logic [2:0]  ASF_UNIMPL   = 3'h0;

   typedef enum logic [3:0] {
      ASF_OP_NOP          = 4'h0,
      ASF_OP_ADD_ACC_FILE = 4'h1,  // add_acc_file_instr
      ASF_OP_ADD_LIT      = 4'h2,  // add_literal_instr
      ASF_OP_SUB_FROM_LIT = 4'h3,  // sub_from_literal_instr: literal - acc
      ASF_OP_SUB_ACC_FILE = 4'h4,  // sub_acc_from_file_instr: file - acc
      ASF_OP_AND_ACC_FILE = 4'h5,  // logic and of acc and file
      ASF_OP_CLR_FILE     = 4'h6,  // clear_file_instr
      ASF_OP_BIT_CLR      = 4'h7,  // bit_clear_instr
      ASF_OP_BIT_SET      = 4'h8,  // bit_set_instr
      ASF_OP_NIB_SWAP     = 4'h9,  // nibble_swap_instr
      ASF_OP_MOVE_FF      = 4'ha,  // file_to_file_move_instr
      ASF_OP_MOVE_ACC     = 4'hb,  // acc_to_file_move_instr
      ASF_OP_ROT_RIGHT    = 4'hc,  // rotate_right_instr, through carry
      ASF_OP_ROT_LEFT     = 4'hd   // rotate_left_instr, through carry
   } asf_op_e;

   typedef enum logic [2:0] {
      ASF_AM_INHERENT = 3'h0,
      ASF_AM_LITERAL  = 3'h1,
      ASF_AM_DIRECT   = 3'h2,
      ASF_AM_INDIRECT = 3'h3,
      ASF_AM_INDEXED  = 3'h4
   } asf_am_e;

   // one bit per addressing mode, index = mode code
   typedef logic [4:0] asf_am_mask_t;
   localparam asf_am_mask_t ASF_AMM_INH  = 5'h01;
   localparam asf_am_mask_t ASF_AMM_LIT  = 5'h02;
   localparam asf_am_mask_t ASF_AMM_FILE = 5'h1c;  // direct, indirect, indexed

   function automatic asf_am_mask_t asf_modes_of(input asf_op_e op);
      asf_am_mask_t m;
      m = ASF_AMM_INH;
      case (op)
         ASF_OP_NOP:   m = ASF_AMM_INH;
         ASF_OP_ADD_LIT:      m = ASF_AMM_LIT;
         ASF_OP_SUB_FROM_LIT: m = ASF_AMM_LIT;
         default:      m = ASF_AMM_FILE;
      endcase
      return m;
   endfunction : asf_modes_of
endpackage : asf_pkg

// file: src/asf_adder.sv
// adder: 8-bit sum with nibble carry, carry and signed overflow
`timescale 1ns/1ps
module asf_adder
   import asf_pkg::*;
(
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic       cin,
   output logic      [7:0] sum,
   output logic            c_nib,
   output logic            c_out,
   output logic            ovf
);
   logic [4:0] lo;
   logic [4:0] hi;

   always_comb begin
      lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      hi    = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      sum   = {hi[3:0], lo[3:0]};
      c_nib = lo[4];
      c_out = hi[4];
      // sign flips only when both inputs share a sign the sum lacks
      ovf   = (a[ASF_MSB] == b[ASF_MSB]) && (sum[ASF_MSB] != a[ASF_MSB]);
   end
endmodule : asf_adder

// file: src/alu_status_flags.sv
// alu status flags: flag derivation, flag register as operand, mode check
// Overview of operation
// - flag register may be the source or destination operand of any instruction.
// - flag-affecting instruction aimed at flags drops its result, updates flags instead.
// - clear aimed at flag register sets zero flag only, others unchanged.
// - bit clear/set, swap and both moves never touch flags; they write it directly.
// - top three bits unimplemented; read as zero, writes ignored.
// - negative flag (bit 4) copies result msb; clear leaves it unchanged.
// - overflow flag (bit 3) set when signed result changes sign wrongly.
// - zero flag (bit 2) set when arithmetic or logic result is zero.
// - add/subtract set nibble carry (bit 1) from carry out of bit 3.
// - add/subtract set carry (bit 0) from carry out of msb.
// - subtract adds two's complement; carries mean "no borrow".
// - rotates load nibble carry from source bit 4 or bit 3.
// - rotates load carry from source high or low bit.
// - inherent, literal, direct, indirect modes; each op allows at most three.
// - indexed literal offset mode only when extended set enable is one.
`timescale 1ns/1ps
module alu_status_flags
   import asf_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       instr_valid,
   input  wire asf_op_e    instr_op,
   input  wire asf_am_e    instr_mode,
   input  wire logic [7:0] file_data,
   input  wire logic [7:0] acc_data,
   input  wire logic [7:0] literal_data,
   input  wire logic [2:0] bit_sel,
   input  wire logic       src_is_flags,
   input  wire logic       dest_is_flags,
   input  wire logic       extended_set_enable,
   output logic      [7:0] result_out,
   output logic            result_write,
   output logic      [7:0] alu_flags,
   output logic            mode_fault
);
   typedef struct packed {
      logic [4:0] flags;
      logic [7:0] result;
      logic       write;
      logic       fault;
   } asf_state_s;

   asf_state_s st_reg;
   asf_state_s st_next;

   logic [7:0] flags_rd;
   logic [7:0] src_val;
   logic [7:0] add_a;
   logic [7:0] add_b;
   logic       add_cin;
   logic [7:0] add_sum;
   logic       add_cnib;
   logic       add_cout;
   logic       add_ovf;

   // flag register as read operand, upper bits tied low
   assign flags_rd = {ASF_UNIMPL, st_reg.flags};
   assign src_val  = src_is_flags ? flags_rd : file_data;

   always_comb begin
      add_a   = acc_data;
      add_b   = src_val;
      add_cin = 1'b0;
      case (instr_op)
         ASF_OP_ADD_LIT: add_b = literal_data;
         ASF_OP_SUB_FROM_LIT: begin
            add_a   = literal_data;
            add_b   = ~acc_data;
            add_cin = 1'b1;
         end
         ASF_OP_SUB_ACC_FILE: begin
            add_a   = src_val;
            add_b   = ~acc_data;
            add_cin = 1'b1;
         end
         default: begin
            add_a   = acc_data;
            add_b   = src_val;
            add_cin = 1'b0;
         end
      endcase
   end

   asf_adder i_asf_adder (
      .a     (add_a),
      .b     (add_b),
      .cin   (add_cin),
      .sum   (add_sum),
      .c_nib (add_cnib),
      .c_out (add_cout),
      .ovf   (add_ovf)
   );

   always_comb begin
      logic [7:0] res;
      logic [4:0] fl;
      logic       affects;
      logic       mode_ok;
      asf_am_mask_t modes;
      res     = ASF_ZERO8;
      modes   = asf_modes_of(instr_op);
      fl      = st_reg.flags;
      affects = 1'b0;
      mode_ok = 1'b0;
      st_next = st_reg;
      st_next.write = 1'b0;
      st_next.fault = 1'b0;
      // indexed mode exists only with the extended set
      // undefined mode codes refused rather than indexing past the mask
      mode_ok = (instr_mode <= ASF_AM_INDEXED) && modes[instr_mode]
                && !(instr_mode == ASF_AM_INDEXED && !extended_set_enable);
      if (instr_valid && !mode_ok) begin
         st_next.fault = 1'b1;
      end else if (instr_valid) begin
         case (instr_op)
            ASF_OP_ADD_ACC_FILE, ASF_OP_ADD_LIT, ASF_OP_SUB_FROM_LIT, ASF_OP_SUB_ACC_FILE: begin
               res                = add_sum;
               affects            = 1'b1;
               fl[ASF_N_BIT]      = res[ASF_MSB];
               fl[ASF_SOVF_BIT]   = add_ovf;
               fl[ASF_Z_BIT]      = (res == ASF_ZERO8);
               fl[ASF_NCY_BIT]    = add_cnib;
               fl[ASF_C_BIT]      = add_cout;
            end
            ASF_OP_AND_ACC_FILE: begin
               res                = acc_data & src_val;
               affects            = 1'b1;
               fl[ASF_N_BIT]      = res[ASF_MSB];
               fl[ASF_Z_BIT]      = (res == ASF_ZERO8);
            end
            ASF_OP_CLR_FILE: begin
               res                = ASF_ZERO8;
               affects            = 1'b1;
               fl[ASF_Z_BIT]      = 1'b1;
            end
            ASF_OP_ROT_RIGHT: begin
               res                = {st_reg.flags[ASF_C_BIT], src_val[ASF_MSB:1]};
               affects            = 1'b1;
               fl[ASF_C_BIT]      = src_val[ASF_LSB];
               fl[ASF_NCY_BIT]    = src_val[ASF_NIB_HI];
               fl[ASF_N_BIT]      = res[ASF_MSB];
               fl[ASF_Z_BIT]      = (res == ASF_ZERO8);
            end
            ASF_OP_ROT_LEFT: begin
               res                = {src_val[ASF_MSB-1:0], st_reg.flags[ASF_C_BIT]};
               affects            = 1'b1;
               fl[ASF_C_BIT]      = src_val[ASF_MSB];
               fl[ASF_NCY_BIT]    = src_val[ASF_NIB_LO];
               fl[ASF_N_BIT]      = res[ASF_MSB];
               fl[ASF_Z_BIT]      = (res == ASF_ZERO8);
            end
            ASF_OP_BIT_CLR:  res = src_val & ~(ASF_ONE8 << bit_sel);
            ASF_OP_BIT_SET:  res = src_val | (ASF_ONE8 << bit_sel);
            ASF_OP_NIB_SWAP: res = {src_val[3:0], src_val[7:4]};
            ASF_OP_MOVE_FF:  res = src_val;
            ASF_OP_MOVE_ACC: res = acc_data;
            default:      res = ASF_ZERO8;
         endcase
         if (instr_op != ASF_OP_NOP) begin
            if (dest_is_flags && affects) begin
               // computed value dropped, so e.g. a clear can leave flags nonzero
               st_next.flags = fl;
            end else if (dest_is_flags) begin
               st_next.flags = res[ASF_FW-1:0];
               st_next.write = 1'b1;
               st_next.result = res;
            end else begin
               st_next.flags  = fl;
               st_next.write  = 1'b1;
               st_next.result = res;
            end
         end
      end
   end

   // flags and result land on the same edge; synchronous reset clears flags to zero
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_reg.flags  <= ASF_FLAGS_RST;
         st_reg.result <= ASF_ZERO8;
         st_reg.write  <= 1'b0;
         st_reg.fault  <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign result_out   = st_reg.result;
   assign result_write = st_reg.write;
   assign alu_flags    = {ASF_UNIMPL, st_reg.flags};
   assign mode_fault   = st_reg.fault;
endmodule : alu_status_flags

// file: testbench/alu_status_flags_monitor.sv
// checker: flag register behaviour seen at the block ports
`timescale 1ns/1ps
module asf_monitor
   import asf_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       resetn,
   input wire logic       instr_valid,
   input wire asf_op_e    instr_op,
   input wire asf_am_e    instr_mode,
   input wire logic [7:0] file_data,
   input wire logic [7:0] acc_data,
   input wire logic [7:0] literal_data,
   input wire logic [2:0] bit_sel,
   input wire logic       src_is_flags,
   input wire logic       dest_is_flags,
   input wire logic       extended_set_enable,
   input wire logic [7:0] result_out,
   input wire logic       result_write,
   input wire logic [7:0] alu_flags,
   input wire logic       mode_fault
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire go   = instr_valid && !dest_is_flags;
   wire addl = go && instr_op == ASF_OP_ADD_LIT && instr_mode == ASF_AM_LITERAL;
   property p_unimpl; alu_flags[7:5] == 3'h0; endproperty
   property p_nz; addl |=> alu_flags[4] == result_out[7] && alu_flags[2] == (result_out == 8'h00); endproperty
   property p_cy;
      addl |=> alu_flags[1:0] == {({1'b0, $past(acc_data[3:0])} + {1'b0, $past(literal_data[3:0])}) > 5'h0f,
                                  ({1'b0, $past(acc_data)} + {1'b0, $past(literal_data)}) > 9'h0ff};
   endproperty
   property p_ov;
      addl |=> alu_flags[3] == ($past(acc_data[7]) == $past(literal_data[7]) && result_out[7] != $past(acc_data[7]));
   endproperty
   property p_keep;
      go && instr_op inside {ASF_OP_BIT_CLR, ASF_OP_BIT_SET, ASF_OP_NIB_SWAP, ASF_OP_MOVE_FF, ASF_OP_MOVE_ACC}
         |=> $stable(alu_flags);
   endproperty
   property p_clr;
      instr_valid && dest_is_flags && instr_op == ASF_OP_CLR_FILE && instr_mode == ASF_AM_DIRECT
         |=> alu_flags == ($past(alu_flags) | 8'h04);
   endproperty
   property p_dest;
      instr_valid && dest_is_flags && instr_mode == ASF_AM_DIRECT && instr_op inside {ASF_OP_ADD_ACC_FILE,
         ASF_OP_SUB_ACC_FILE, ASF_OP_AND_ACC_FILE, ASF_OP_CLR_FILE, ASF_OP_ROT_RIGHT, ASF_OP_ROT_LEFT}
         |=> !result_write;
   endproperty
   property p_idx;
      instr_valid && instr_mode == ASF_AM_INDEXED && !extended_set_enable && instr_op != ASF_OP_NOP
         |=> mode_fault && $stable(alu_flags);
   endproperty
   property p_rot;
      go && instr_op == ASF_OP_ROT_RIGHT && instr_mode == ASF_AM_DIRECT && !src_is_flags
         |=> alu_flags[1:0] == {$past(file_data[4]), $past(file_data[0])};
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("upper flag bits set");
   a_nz: assert property (p_nz) else $error("sign or zero flag wrong");
   a_cy: assert property (p_cy) else $error("carry flags wrong");
   a_ov: assert property (p_ov) else $error("overflow flag wrong");
   a_keep: assert property (p_keep) else $error("flags moved on a move or bit op");
   a_clr: assert property (p_clr) else $error("clear of flags wrong");
   a_dest: assert property (p_dest) else $error("result written for flag target");
   a_idx: assert property (p_idx) else $error("indexed mode not refused");
   a_rot: assert property (p_rot) else $error("rotate carries wrong");
   c_add: cover property (addl);
   c_fault: cover property (mode_fault);
   c_dest: cover property (instr_valid && dest_is_flags);
endmodule : asf_monitor

bind alu_status_flags asf_monitor i_asf_monitor (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid),
   .instr_op(instr_op), .instr_mode(instr_mode), .file_data(file_data), .acc_data(acc_data),
   .literal_data(literal_data), .bit_sel(bit_sel), .src_is_flags(src_is_flags), .dest_is_flags(dest_is_flags),
   .extended_set_enable(extended_set_enable), .result_out(result_out), .result_write(result_write),
   .alu_flags(alu_flags), .mode_fault(mode_fault));

// file: testbench/alu_status_flags_bench.sv
// bench: directed scenarios for the status flag block
`timescale 1ns/1ps
module alu_status_flags_bench;
   import asf_pkg::*;
   logic       clk_sys, resetn, instr_valid, src_is_flags, dest_is_flags, extended_set_enable;
   asf_op_e    instr_op;
   asf_am_e    instr_mode;
   logic [7:0] file_data, acc_data, literal_data, result_out, alu_flags;
   logic [2:0] bit_sel;
   logic       result_write, mode_fault;
   int         num_errors, check_count;
   alu_status_flags i_alu_status_flags (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_mode(instr_mode), .file_data(file_data), .acc_data(acc_data),
      .literal_data(literal_data), .bit_sel(bit_sel), .src_is_flags(src_is_flags), .dest_is_flags(dest_is_flags),
      .extended_set_enable(extended_set_enable), .result_out(result_out), .result_write(result_write),
      .alu_flags(alu_flags), .mode_fault(mode_fault));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // inputs move 1 ns after the edge; outputs read once the taking edge has landed
   task automatic run(input asf_op_e op, input asf_am_e m, input logic [7:0] f, a, l, input logic df);
      @(posedge clk_sys);
      #1;
      instr_op = op;
      instr_mode = m;
      file_data = f;
      acc_data = a;
      literal_data = l;
      dest_is_flags = df;
      instr_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      instr_valid = 1'b0;
   endtask : run
   task automatic t_add;
      run(ASF_OP_ADD_LIT, ASF_AM_LITERAL, 8'h00, 8'h7f, 8'h01, 1'b0);
      chk("sum", 8'h80, result_out);
      chk("add flags", 8'h1a, alu_flags);
      run(ASF_OP_ADD_ACC_FILE, ASF_AM_DIRECT, 8'hff, 8'h01, 8'h00, 1'b0);
      chk("wrap flags", 8'h07, alu_flags);
   endtask : t_add
   task automatic t_sub;
      run(ASF_OP_SUB_FROM_LIT, ASF_AM_LITERAL, 8'h00, 8'h06, 8'h05, 1'b0);
      chk("borrow flags", 8'h10, alu_flags);
      run(ASF_OP_SUB_ACC_FILE, ASF_AM_DIRECT, 8'h10, 8'h01, 8'h00, 1'b0);
      chk("sub result", 8'h0f, result_out);
      chk("no borrow flags", 8'h01, alu_flags);
   endtask : t_sub
   task automatic t_dest;
      run(ASF_OP_ADD_LIT, ASF_AM_LITERAL, 8'h00, 8'h7f, 8'h01, 1'b1);
      chk("dest write", 8'h00, {7'h0, result_write});
      chk("dest flags", 8'h1a, alu_flags);
      run(ASF_OP_CLR_FILE, ASF_AM_DIRECT, 8'h00, 8'h00, 8'h00, 1'b1);
      chk("clear flags", 8'h1e, alu_flags);
      run(ASF_OP_MOVE_ACC, ASF_AM_DIRECT, 8'h00, 8'hff, 8'h00, 1'b1);
      chk("moved flags", 8'h1f, alu_flags);
      src_is_flags = 1'b1;
      run(ASF_OP_MOVE_FF, ASF_AM_DIRECT, 8'haa, 8'h00, 8'h00, 1'b0);
      src_is_flags = 1'b0;
      chk("flags as source", 8'h1f, result_out);
   endtask : t_dest
   task automatic t_keep;
      asf_op_e ops[5] = '{ASF_OP_BIT_CLR, ASF_OP_BIT_SET, ASF_OP_NIB_SWAP, ASF_OP_MOVE_FF, ASF_OP_MOVE_ACC};
      foreach (ops[i]) begin
         bit_sel = 3'(i);
         run(ops[i], ASF_AM_INDIRECT, 8'h00, 8'h00, 8'h00, 1'b0);
         chk("kept flags", 8'h1f, alu_flags);
      end
   endtask : t_keep
   task automatic t_rot;
      run(ASF_OP_ROT_RIGHT, ASF_AM_DIRECT, 8'h10, 8'h00, 8'h00, 1'b0);
      chk("rotate right carries", 8'h02, {6'h0, alu_flags[1:0]});
      run(ASF_OP_ROT_LEFT, ASF_AM_DIRECT, 8'h81, 8'h00, 8'h00, 1'b0);
      chk("rotate left carries", 8'h01, {6'h0, alu_flags[1:0]});
   endtask : t_rot
   task automatic t_mode;
      run(ASF_OP_ADD_ACC_FILE, ASF_AM_LITERAL, 8'h01, 8'h01, 8'h00, 1'b0);
      chk("bad mode", 8'h01, {7'h0, mode_fault});
      run(ASF_OP_ADD_ACC_FILE, ASF_AM_INDEXED, 8'h01, 8'h01, 8'h00, 1'b0);
      chk("indexed off", 8'h01, {7'h0, mode_fault});
      extended_set_enable = 1'b1;
      run(ASF_OP_ADD_ACC_FILE, ASF_AM_INDEXED, 8'h01, 8'h01, 8'h00, 1'b0);
      chk("indexed on", 8'h01, {7'h0, result_write});
   endtask : t_mode
   task automatic stop_test;
      if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // generous bound: the whole run needs well under 100 cycles
   initial begin
      #200000;
      num_errors++;
      stop_test();
   end
   initial begin
      {resetn, instr_valid, src_is_flags, dest_is_flags, extended_set_enable} = 5'h00;
      {file_data, acc_data, literal_data, bit_sel} = 27'h0;
      instr_op = ASF_OP_NOP;
      instr_mode = ASF_AM_INHERENT;
      repeat (2) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      t_add();
      t_sub();
      t_dest();
      t_keep();
      t_rot();
      t_mode();
      stop_test();
   end
endmodule : alu_status_flags_bench
